// *** tsz_xor_pkg.sv ***
/*
  Shared constants for the zero-test-and-skip and literal XOR execution block.
  Assumes a 16-bit instruction word and an 8-bit data path.
*/
package tsz_xor_pkg;
  localparam int          DATA_W          = 8;
  localparam int          INSN_W          = 16;
  localparam int          ADDR_W          = 12;
  localparam int          BANK_W          = 4;
  // Opcode match fields
  localparam logic [6:0]  OPC_TSTZ        = 7'h33;   // 0110 011
  localparam logic [7:0]  OPC_XORL        = 8'h0a;   // 0000 1010
  localparam int          ACCESS_BIT      = 8;
  // Access bank split and indexed window limit
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [7:0]  INDEX_MAX       = 8'h5f;
  localparam logic [3:0]  BANK_HIGH       = 4'hf;
  // Flag positions in the status byte
  localparam int          FLAG_Z          = 2;
  localparam int          FLAG_N          = 4;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [7:0]  WORK_RESET      = 8'h00;
  // Two-word instruction prefixes (upper nibble, upper 7 bits or upper byte)
  localparam logic [3:0]  TWO_WORD_C      = 4'hc;
  localparam logic [7:0]  TWO_WORD_CALL   = 8'hec;
  localparam logic [7:0]  TWO_WORD_GOTO   = 8'hef;
  localparam logic [6:0]  TWO_WORD_LFSR   = 7'h77;
  typedef enum logic [1:0] {ST_EXEC, ST_SKIP1, ST_SKIP2} exec_state_t;
endpackage : tsz_xor_pkg

// *** operand_addr.sv ***
/*
  Resolves the 8-bit file operand of a byte instruction to a data address.
  Assumes the index base register is supplied by the surrounding core.
*/
`timescale 1ns/1ns
module operand_addr
  import tsz_xor_pkg::*;
(
  // Operand and selection
  input  wire logic [7:0]               file_operand,
  input  wire logic                     access_bit,
  input  wire logic                     ext_set_en,
  input  wire logic [BANK_W-1:0]        bank_select_register,
  input  wire logic [ADDR_W-1:0]        index_base,
  // Result
  output logic      [ADDR_W-1:0]        data_addr,
  output logic                          indexed
);
  import tsz_xor_pkg::*;

  wire logic [ADDR_W-1:0] banked_addr;
  wire logic [ADDR_W-1:0] access_addr;
  wire logic [ADDR_W-1:0] index_addr;

  assign indexed     = !access_bit && ext_set_en && (file_operand <= INDEX_MAX);
  assign banked_addr = {bank_select_register, file_operand};
  assign access_addr = (file_operand < ACCESS_SPLIT) ? {4'h0, file_operand}
                                                     : {BANK_HIGH, file_operand};
  assign index_addr  = ADDR_W'(index_base + {4'h0, file_operand});
  assign data_addr   = access_bit ? banked_addr : (indexed ? index_addr : access_addr);
endmodule : operand_addr

// *** tsz_xor_exec.sv ***
/*
  Execution of the zero-test-and-skip and literal XOR instructions.
  Assumes one instruction cycle per core_clk rising edge, the next word already
  prefetched on fetch_word, and file data returned combinationally.
*/
`timescale 1ns/1ns
module tsz_xor_exec
  import tsz_xor_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Instruction stream
  input  wire logic                     insn_valid,
  input  wire logic [INSN_W-1:0]        insn_word,
  input  wire logic [INSN_W-1:0]        fetch_word,
  // Operand addressing
  input  wire logic                     ext_set_en,
  input  wire logic [BANK_W-1:0]        bank_select_register,
  input  wire logic [ADDR_W-1:0]        index_base,
  output logic      [ADDR_W-1:0]        file_addr,
  output logic                          file_rd,
  output logic                          file_indexed,
  input  wire logic [DATA_W-1:0]        file_data,
  // Execution state
  output logic                          insn_ready,
  output logic                          nop_cycle,
  output logic                          skip_taken,
  output logic      [DATA_W-1:0]        working_reg,
  output logic      [DATA_W-1:0]        status_reg
);
  import tsz_xor_pkg::*;

  exec_state_t          state_r;
  exec_state_t          state_nxt;
  logic [DATA_W-1:0]    work_r;
  logic [DATA_W-1:0]    work_nxt;
  logic [DATA_W-1:0]    stat_r;
  logic [DATA_W-1:0]    stat_nxt;
  logic                 skip_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic            exec_slot;
  wire logic            is_tstz;
  wire logic            is_xorl;
  wire logic            file_zero;
  wire logic            do_skip;
  wire logic            next_two_word;
  wire logic [DATA_W-1:0] xor_result;

  assign exec_slot  = (state_r == ST_EXEC) && insn_valid;
  assign is_tstz    = exec_slot && (insn_word[15:9] == OPC_TSTZ);
  assign is_xorl    = exec_slot && (insn_word[15:8] == OPC_XORL);
  assign file_zero  = (file_data == 8'h00);
  assign do_skip    = is_tstz && file_zero;
  assign next_two_word = (fetch_word[15:12] == TWO_WORD_C)
                      || (fetch_word[15:8] == TWO_WORD_CALL)
                      || (fetch_word[15:8] == TWO_WORD_GOTO)
                      || (fetch_word[15:9] == TWO_WORD_LFSR)
                      || (fetch_word[15:8] == 8'heb);
  assign xor_result = work_r ^ insn_word[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Operand address
  operand_addr u_operand_addr (
    .file_operand         (insn_word[7:0]),
    .access_bit           (insn_word[ACCESS_BIT]),
    .ext_set_en           (ext_set_en),
    .bank_select_register (bank_select_register),
    .index_base           (index_base),
    .data_addr            (file_addr),
    .indexed              (file_indexed)
  );

  assign file_rd = is_tstz;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing of skip cycles
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_EXEC: begin
        if (do_skip) begin
          state_nxt = next_two_word ? ST_SKIP2 : ST_SKIP1;
        end
      end
      ST_SKIP2: begin
        state_nxt = ST_SKIP1;
      end
      ST_SKIP1: begin
        state_nxt = ST_EXEC;
      end
      default: begin
        state_nxt = ST_EXEC;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register and flags
  always_comb begin
    work_nxt = work_r;
    stat_nxt = stat_r;
    if (is_xorl) begin
      work_nxt         = xor_result;
      stat_nxt[FLAG_N] = xor_result[DATA_W-1];
      stat_nxt[FLAG_Z] = (xor_result == 8'h00);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_EXEC;
      work_r  <= WORK_RESET;
      stat_r  <= STATUS_RESET;
      skip_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      work_r  <= work_nxt;
      stat_r  <= stat_nxt;
      skip_r  <= do_skip;
    end
  end

  assign insn_ready  = (state_r == ST_EXEC);
  assign nop_cycle   = (state_r != ST_EXEC);
  assign skip_taken  = skip_r;
  assign working_reg = work_r;
  assign status_reg  = stat_r;
endmodule : tsz_xor_exec

// *** tsz_xor_exec_sva.sv ***
/* Checker for the zero-test-and-skip and literal XOR block.
   Bound to every instance; sees only the block's ports. */
`timescale 1ns/1ns
module tsz_xor_exec_sva
  import tsz_xor_pkg::*;
(
  // Watched ports
  input wire logic              core_clk, rst_n, insn_valid, ext_set_en,
  input wire logic              nop_cycle, insn_ready, file_indexed, file_rd,
  input wire logic [INSN_W-1:0] insn_word, fetch_word,
  input wire logic [BANK_W-1:0] bank_select_register,
  input wire logic [ADDR_W-1:0] index_base, file_addr,
  input wire logic [DATA_W-1:0] file_data, working_reg, status_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire [7:0] f   = insn_word[7:0];
  wire       tst = insn_valid && insn_ready && insn_word[15:9] == OPC_TSTZ;
  wire       xl  = insn_valid && insn_ready && insn_word[15:8] == OPC_XORL;
  wire       sk  = tst && file_data == 8'h00;
  wire       idx = !insn_word[8] && ext_set_en && f <= INDEX_MAX;
  wire       two = fetch_word[15:12] == TWO_WORD_C || fetch_word[15:9] == TWO_WORD_LFSR
    || fetch_word[15:8] inside {8'heb, TWO_WORD_CALL, TWO_WORD_GOTO};
  ////////////////////////////////////////
  property p_skip1; sk && !two |=> nop_cycle && !insn_ready ##1 !nop_cycle; endproperty
  a_skip1: assert property (p_skip1) else $error("short skip wrong");
  property p_noskip; tst && !sk |=> !nop_cycle; endproperty
  a_noskip: assert property (p_noskip) else $error("skip without zero");
  property p_skip2; sk && two |=> nop_cycle[*2] ##1 !nop_cycle; endproperty
  a_skip2: assert property (p_skip2) else $error("long skip wrong");
  property p_acc; tst && !insn_word[8] && !idx |->
    file_addr == {f < ACCESS_SPLIT ? 4'h0 : BANK_HIGH, f} && !file_indexed; endproperty
  a_acc: assert property (p_acc) else $error("access bank address");
  property p_bank; tst && insn_word[8] |-> file_addr == {bank_select_register, f}; endproperty
  a_bank: assert property (p_bank) else $error("banked address");
  property p_idx; tst && idx |-> file_indexed && file_addr == index_base + {4'h0, f}; endproperty
  a_idx: assert property (p_idx) else $error("indexed address");
  property p_xor; xl |=> working_reg == ($past(working_reg) ^ $past(f)) &&
    status_reg == {3'h0, working_reg[7], 1'h0, working_reg == 8'h00, 2'h0}; endproperty
  a_xor: assert property (p_xor) else $error("xor result or flags");
  property p_keep; tst |-> file_rd ##1 $stable(working_reg) && $stable(status_reg); endproperty
  a_keep: assert property (p_keep) else $error("zero test wrote state");
  c_skip1: cover property (sk && !two);
  c_skip2: cover property (sk && two);
  c_xor: cover property (xl);
endmodule : tsz_xor_exec_sva

bind tsz_xor_exec tsz_xor_exec_sva u_sva (.core_clk, .rst_n, .insn_valid, .ext_set_en,
  .nop_cycle, .insn_ready, .file_indexed, .file_rd, .insn_word, .fetch_word,
  .bank_select_register, .index_base, .file_addr, .file_data, .working_reg, .status_reg);

// *** test_tsz_xor_exec.sv ***
/* Self-checking bench for the execution block.
   Needs the package, the block and its checker compiled first. */
`timescale 1ns/1ns
module test_tsz_xor_exec;
  import tsz_xor_pkg::*;
  typedef struct packed {
    logic [15:0] insn; logic [7:0] fd; logic [15:0] fw;
    logic [3:0] ext; logic [11:0] addr; logic [7:0] w; logic [3:0] nops;
  } row_t;
  logic        core_clk = '0, rst_n = '0, insn_valid = '0, ext_set_en = '0;
  logic [15:0] insn_word = '0, fetch_word = '0;
  logic [7:0]  file_data = '0, working_reg, status_reg;
  logic [11:0] file_addr;
  logic        file_rd, file_indexed, insn_ready, nop_cycle, skip_taken;
  int          n_errors = 0, total_checks = 0, n;
  row_t        r;
  row_t        rows [11] = '{
    68'h0aaf_00_0000_0_000_af_0, 68'h0aaf_00_0000_0_000_00_0,
    68'h0a5a_00_0000_0_000_5a_0, 68'h6712_00_0000_0_312_5a_1,
    68'h6612_01_0000_0_012_5a_0, 68'h6680_00_c123_0_f80_5a_2,
    68'h665f_00_eb00_1_15f_5a_2, 68'h6660_00_ee00_1_f60_5a_2,
    68'h6700_00_ec00_0_300_5a_2, 68'h6700_00_ef00_0_300_5a_2,
    68'h0aa5_00_0000_0_000_ff_0};
  tsz_xor_exec uut (.core_clk, .rst_n, .insn_valid, .insn_word, .fetch_word, .ext_set_en,
    .bank_select_register(4'h3), .index_base(12'h100), .file_addr, .file_rd, .file_indexed,
    .file_data, .insn_ready, .nop_cycle, .skip_taken, .working_reg, .status_reg);
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d, checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #20000 n_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    check({working_reg, status_reg}, 16'h0);
    check({nop_cycle, insn_ready, skip_taken}, 16'h2);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge core_clk);
      insn_valid <= 1'b1;
      insn_word <= r.insn;
      file_data <= r.fd;
      fetch_word <= r.fw;
      ext_set_en <= r.ext[0];
      #1 if (r.insn[15:12] == 4'h6) check(file_addr, r.addr);
      check(file_rd, r.insn[15:9] == OPC_TSTZ);
      check(file_indexed, r.insn[15:12] == 4'h6 && r.ext[0] && !r.insn[8]
        && r.insn[7:0] <= INDEX_MAX);
      @(posedge core_clk);
      insn_valid <= 1'b0;
      #1 check(working_reg, r.w);
      check(status_reg, {r.w[7], 1'h0, r.w == 8'h00, 2'h0});
      check(skip_taken, r.nops != 4'h0);
      for (n = 0; nop_cycle === 1'b1 && n < 4; n++) @(posedge core_clk) #1;
      check(n, r.nops);
    end
    // Skip then an XOR offered in the discarded cycle
    @(posedge core_clk);
    insn_valid <= 1'b1;
    insn_word <= 16'h6700;
    fetch_word <= '0;
    @(posedge core_clk);
    insn_word <= 16'h0aff;
    @(posedge core_clk);
    insn_valid <= 1'b0;
    @(posedge core_clk) #1 check(working_reg, 8'hff);
    @(posedge core_clk);
    rst_n <= 1'b0;
    #1 check({working_reg, status_reg}, 16'h0);
    check({nop_cycle, insn_ready, skip_taken}, 16'h2);
    close_out();
  end
endmodule : test_tsz_xor_exec
